// >>> sfm_top.sv
// System failure manager: latching, priority, stop control, speed filter, monitor
// Notes on behaviour
// RL1: Ten sources on mask bits 0 to 9
// RL2: Source counts only when its mask bit set
// RL3: Action bit 0 decelerates, 1 brakes
// RL4: Brake sequence fault always brakes
// RL5: Failure output on any enabled failure, polarity
// RL6: Priority brake seq, limit, estop, others
// RL7: S-curve stop waits out acceleration
// RL8: Linear stop from frequency at detection
// RL9: Failure stop skips creep speed
// RL10: Linear failure stop disables sway, adaptive control
// RL11: Brake stop drops brake open command
// RL12: Speed from position, lag filtered, judged
// RL13: Operator stops, reads, fixes, then resets
// RL14: Low byte holds first failure code
// RL15: High byte holds highest priority code
// RL16: Codes 1 to 10 follow bit order
// RL17: Monitor shows code at selection 97
// RL18: Monitor shows speed at selection 67
// RL19: Failures stay latched until drive reset
// RL20: Stop starts cycle after first latch
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module sfm_top
  import sfm_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [9:0]  i_fail_src,
  input  wire logic        i_run_cmd,
  input  wire logic        i_accel,
  input  wire logic [15:0] i_out_freq,
  input  wire logic        i_brake_open_req,
  input  wire logic [31:0] i_pos,
  input  wire logic        i_pos_valid,
  output logic             o_failure_output,
  output logic             o_brake_open_cmd,
  output logic             o_run_en,
  output logic      [15:0] o_freq_cmd,
  output logic             o_creep_en,
  output logic             o_antisway_en,
  output logic             o_adaptive_en,
  output logic      [15:0] o_monitor
);

  // Code of the winning failure among a latched set
  function automatic logic [7:0] prio_code(input logic [NUM_SRC-1:0] lat,
                                           input logic [15:0] act);
    logic [7:0] code;
    code = CODE_NONE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (lat[i]) begin
        code = 8'(i + 1);
      end
    end
    if (lat[SRC_ESTOP] && act[SRC_ESTOP]) begin
      code = CODE_ESTOP;
    end
    if (lat[SRC_LIMIT] && act[SRC_LIMIT]) begin
      code = CODE_LIMIT;
    end
    if (lat[SRC_BRKSEQ]) begin
      code = CODE_BRKSEQ;
    end
    return code;
  endfunction

  // Stop action of a code: brake sequence fault ignores its action bit
  function automatic logic code_brakes(input logic [7:0] code, input logic [15:0] act);
    logic [3:0] idx;
    idx = 4'(code - 8'h01);
    return (code == CODE_BRKSEQ) || ((code != CODE_NONE) && act[idx]);
  endfunction

  logic [15:0]         mask_reg;
  logic [15:0]         act_reg;
  logic [1:0]          ctrl_reg;
  logic [3:0]          filt_shift_reg;
  logic [7:0]          monsel_reg;
  logic [15:0]         ospeed_reg;
  logic [15:0]         dstep_reg;
  logic [NUM_SRC-1:0]  lat_reg;
  logic [NUM_SRC-1:0]  lat_next;
  logic [NUM_SRC-1:0]  src_eff;
  logic [7:0]          first_code_reg;
  logic [7:0]          hi_code_reg;
  logic [7:0]          hi_code_next;
  logic                brake_next;
  logic                first_hit;
  sfm_state_t          state_reg;
  logic [15:0]         freq_reg;
  logic [15:0]         step_reg;
  logic [6:0]          tick_cnt_reg;
  logic                tick_reg;
  logic [31:0]         pos_prev_reg;
  logic signed [23:0]  filt_reg;
  logic signed [15:0]  raw_speed;
  logic signed [23:0]  filt_err;
  logic [15:0]         speed_abs;
  logic                overspeed;
  logic                apb_acc;
  logic                apb_wr;
  logic                lin_sel;
  logic                fail_stop;

  assign lin_sel = ctrl_reg[CTRL_PROFILE_BIT];

  // APB slave, one wait state: pready rises on the second access cycle
  assign apb_acc = i_psel && i_penable && !o_pready;
  assign apb_wr  = i_psel && i_penable && o_pready && i_pwrite;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= apb_acc;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      if (apb_acc) begin
        case (i_paddr)
          OFS_MASK:    o_prdata <= {16'h0000, mask_reg};
          OFS_ACTION:  o_prdata <= {16'h0000, act_reg};
          OFS_CTRL:    o_prdata <= {30'h0, ctrl_reg};
          OFS_FILTER:  o_prdata <= {28'h000_0000, filt_shift_reg};
          OFS_MONSEL:  o_prdata <= {24'h00_0000, monsel_reg};
          OFS_OSPEED:  o_prdata <= {16'h0000, ospeed_reg};
          OFS_DSTEP:   o_prdata <= {16'h0000, dstep_reg};
          OFS_CODEMON: o_prdata <= {16'h0000, hi_code_reg, first_code_reg};
          OFS_STATUS:  o_prdata <= {11'h0, state_reg, 6'h00, lat_reg};
          OFS_SPEED:   o_prdata <= {16'h0000, filt_reg[23:8]};
          default:     o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Writes land on the edge that completes the access; read-only and unmapped ignored
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      mask_reg       <= RST_MASK;
      act_reg        <= RST_ACTION;
      ctrl_reg       <= RST_CTRL;
      filt_shift_reg <= RST_FILTER;
      monsel_reg     <= RST_MONSEL;
      ospeed_reg     <= RST_OSPEED;
      dstep_reg      <= RST_DSTEP;
    end else if (apb_wr) begin
      case (i_paddr)
        OFS_MASK:   mask_reg       <= i_pwdata[15:0];
        OFS_ACTION: act_reg        <= i_pwdata[15:0];
        OFS_CTRL:   ctrl_reg       <= i_pwdata[1:0];
        OFS_FILTER: filt_shift_reg <= i_pwdata[3:0];
        OFS_MONSEL: monsel_reg     <= i_pwdata[7:0];
        OFS_OSPEED: ospeed_reg     <= i_pwdata[15:0];
        OFS_DSTEP:  dstep_reg      <= i_pwdata[15:0];
        default: ;
      endcase
    end
  end

  // RL12 differentiate and filter
  assign raw_speed = signed'(16'(i_pos - pos_prev_reg));
  assign filt_err  = signed'({raw_speed, 8'h00}) - filt_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pos_prev_reg <= 32'h0000_0000;
      filt_reg     <= 24'sh00_0000;
    end else if (i_pos_valid) begin
      pos_prev_reg <= i_pos;
      filt_reg     <= filt_reg + (filt_err >>> filt_shift_reg);
    end
  end

  // RL12 judge overspeed on filtered value
  assign speed_abs = filt_reg[23] ? 16'(-filt_reg[23:8]) : filt_reg[23:8];
  assign overspeed = speed_abs > ospeed_reg;

  // RL1 bit order of sources, overspeed also fed by the filter
  always_comb begin
    src_eff             = i_fail_src;
    src_eff[SRC_OSPEED] = i_fail_src[SRC_OSPEED] || overspeed;
  end

  // RL2 mask gating; RL19 sticky latch
  assign lat_next     = lat_reg | (src_eff & mask_reg[NUM_SRC-1:0]);
  assign first_hit    = (lat_reg == '0) && (lat_next != '0);
  // RL6 priority selects code and action
  assign hi_code_next = prio_code(lat_next, act_reg);
  // RL3 action bit chooses brake or decel; RL4 brake sequence forced
  assign brake_next   = code_brakes(hi_code_next, act_reg);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      lat_reg <= '0;
    end else begin
      lat_reg <= lat_next;
    end
  end

  // RL14 first code kept; RL15 highest priority so far; RL16 code values
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      first_code_reg <= CODE_NONE;
      hi_code_reg    <= CODE_NONE;
    end else begin
      if (first_hit) begin
        first_code_reg <= hi_code_next;
      end
      hi_code_reg <= hi_code_next;
    end
  end

  // Tick divider paces the frequency ramp
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tick_cnt_reg <= 7'h00;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 7'(TICK_CYC - 1)) begin
      tick_cnt_reg <= 7'h00;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 7'h01;
      tick_reg     <= 1'b0;
    end
  end

  // Stop sequencer; a later higher-priority brake failure escalates a running decel
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= ST_RUN;
    end else begin
      case (state_reg)
        ST_RUN: begin
          // RL20 stop starts next cycle
          if (first_hit) begin
            if (brake_next) begin
              state_reg <= ST_BRAKE;
            end else if (!lin_sel && i_accel) begin
              // RL7 S-curve waits for accel end
              state_reg <= ST_HOLD;
            end else begin
              state_reg <= ST_DECEL;
            end
          end
        end
        ST_HOLD: begin
          if (brake_next) begin
            state_reg <= ST_BRAKE;
          end else if (!i_accel) begin
            state_reg <= ST_DECEL;
          end
        end
        ST_DECEL: begin
          if (brake_next) begin
            state_reg <= ST_BRAKE;
          end else if (freq_reg == 16'h0000) begin
            state_reg <= ST_STOP;
          end
        end
        ST_STOP:  state_reg <= brake_next ? ST_BRAKE : ST_STOP;
        ST_BRAKE: state_reg <= ST_BRAKE;
        default:  state_reg <= ST_BRAKE;
      endcase
    end
  end

  // Frequency ramp: S-curve grows its step, linear uses the full step at once
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      freq_reg <= 16'h0000;
      step_reg <= 16'h0000;
    end else if (state_reg == ST_RUN || state_reg == ST_HOLD) begin
      // RL8 linear ramp starts from frequency at detection
      freq_reg <= i_out_freq;
      step_reg <= lin_sel ? dstep_reg : 16'h0001;
    end else if (state_reg == ST_DECEL && tick_reg) begin
      freq_reg <= (freq_reg > step_reg) ? freq_reg - step_reg : 16'h0000;
      if (!lin_sel && step_reg < dstep_reg) begin
        step_reg <= step_reg + 16'h0001;
      end
    end else if (state_reg == ST_BRAKE) begin
      freq_reg <= 16'h0000;
    end
  end

  assign fail_stop = (state_reg == ST_HOLD) || (state_reg == ST_DECEL);

  // Drive-facing outputs, all registered
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_run_en         <= 1'b0;
      o_freq_cmd       <= 16'h0000;
      o_brake_open_cmd <= 1'b0;
      o_creep_en       <= 1'b0;
      o_antisway_en    <= 1'b1;
      o_adaptive_en    <= 1'b1;
    end else begin
      o_run_en   <= i_run_cmd && (state_reg == ST_RUN);
      o_freq_cmd <= (state_reg == ST_RUN) ? i_out_freq : freq_reg;
      // RL11 brake open dropped on brake stop
      o_brake_open_cmd <= i_brake_open_req && (state_reg != ST_BRAKE)
                          && (state_reg != ST_STOP);
      // RL9 no creep once a failure stop runs
      o_creep_en <= (state_reg == ST_RUN);
      // RL10 linear failure stop suspends controls
      o_antisway_en <= !(fail_stop && lin_sel);
      o_adaptive_en <= !(fail_stop && lin_sel);
    end
  end

  // RL5 failure output with selectable polarity
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_failure_output <= 1'b0;
    end else begin
      o_failure_output <= (lat_next != '0) ^ ctrl_reg[CTRL_POL_BIT];
    end
  end

  // Monitor output mux
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_monitor <= 16'h0000;
    end else begin
      case (monsel_reg)
        // RL17 code selection
        MONSEL_CODE:  o_monitor <= {hi_code_reg, first_code_reg};
        // RL18 speed selection
        MONSEL_SPEED: o_monitor <= filt_reg[23:8];
        default:      o_monitor <= 16'h0000;
      endcase
    end
  end

  // Checks
  sequence first_seq;
    (lat_reg == '0) && (lat_next != '0);
  endsequence

  sequence brake_entry_seq;
    (state_reg != ST_BRAKE) ##1 (state_reg == ST_BRAKE);
  endsequence

  mask_gate_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL2
    ((src_eff & mask_reg[NUM_SRC-1:0]) == '0) |=> (lat_reg == $past(lat_reg)))
    else $error("masked source changed latched set");

  latch_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL19
    1'b1 |=> ((lat_reg & $past(lat_reg)) == $past(lat_reg)))
    else $error("latched failure cleared without reset");

  first_code_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL14
    (lat_reg != '0) |=> $stable(first_code_reg))
    else $error("first failure code changed");

  brake_prio_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL6
    lat_reg[SRC_BRKSEQ] |=> (hi_code_reg == CODE_BRKSEQ) && (state_reg == ST_BRAKE))
    else $error("brake sequence fault not top priority");

  brake_drop_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL11
    brake_entry_seq |=> !o_brake_open_cmd [*3])
    else $error("brake open still asserted on brake stop");

  fail_out_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL5
    (lat_reg != '0) |=> (o_failure_output == !$past(ctrl_reg[CTRL_POL_BIT])))
    else $error("failure output not asserted");

  stop_start_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL20
    first_seq |=> (state_reg != ST_RUN) ##1 !o_run_en)
    else $error("stop action did not start");

  scurve_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL7
    first_seq ##0 (!lin_sel && i_accel && !brake_next) |=> (state_reg == ST_HOLD))
    else $error("S-curve stop did not wait for acceleration");

  sway_off_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL10
    (fail_stop && lin_sel) |=> !o_antisway_en && !o_adaptive_en && !o_creep_en)
    else $error("controls active during linear failure stop");

  code_mon_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // RL17
    (monsel_reg == MONSEL_CODE) |=> (o_monitor == $past({hi_code_reg, first_code_reg})))
    else $error("code monitor mismatch");

endmodule

// >>> sfm_pkg.sv
// Package of constants and types for the system failure manager
package sfm_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] OFS_MASK    = 8'h00;
  localparam logic [7:0] OFS_ACTION  = 8'h04;
  localparam logic [7:0] OFS_CTRL    = 8'h08;
  localparam logic [7:0] OFS_FILTER  = 8'h0C;
  localparam logic [7:0] OFS_MONSEL  = 8'h10;
  localparam logic [7:0] OFS_OSPEED  = 8'h14;
  localparam logic [7:0] OFS_DSTEP   = 8'h18;
  localparam logic [7:0] OFS_CODEMON = 8'h1C;
  localparam logic [7:0] OFS_STATUS  = 8'h20;
  localparam logic [7:0] OFS_SPEED   = 8'h24;

  // Reset values
  localparam logic [15:0] RST_MASK   = 16'hFFFF;
  localparam logic [15:0] RST_ACTION = 16'h0000;
  localparam logic [1:0]  RST_CTRL   = 2'h0;
  localparam logic [3:0]  RST_FILTER = 4'h4;
  localparam logic [7:0]  RST_MONSEL = 8'h00;
  localparam logic [15:0] RST_OSPEED = 16'h7FFF;
  localparam logic [15:0] RST_DSTEP  = 16'h0010;

  // Control register fields
  localparam int CTRL_PROFILE_BIT = 0;
  localparam int CTRL_POL_BIT     = 1;

  // Failure source positions and count
  localparam int NUM_SRC     = 10;
  localparam int SRC_OSPEED  = 0;
  localparam int SRC_LIMIT   = 6;
  localparam int SRC_BRKSEQ  = 7;
  localparam int SRC_ESTOP   = 8;

  // Failure codes
  localparam logic [7:0] CODE_NONE   = 8'h00;
  localparam logic [7:0] CODE_LIMIT  = 8'h07;
  localparam logic [7:0] CODE_BRKSEQ = 8'h08;
  localparam logic [7:0] CODE_ESTOP  = 8'h09;

  // Monitor selection values
  localparam logic [7:0] MONSEL_CODE  = 8'h61;
  localparam logic [7:0] MONSEL_SPEED = 8'h43;

  // Deceleration tick timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,
    ST_HOLD  = 5'b00010,
    ST_DECEL = 5'b00100,
    ST_STOP  = 5'b01000,
    ST_BRAKE = 5'b10000
  } sfm_state_t;
endpackage

// >>> sfm_drive_model.sv
// Model of the motor drive, mechanical brake and distance meter
`timescale 1ns/1ps
module sfm_drive_model (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_start,
  input  wire logic        i_accel_req,
  input  wire logic        i_meter_on,
  input  wire logic [15:0] i_target,
  input  wire logic [15:0] i_step,
  input  wire logic        i_run_en,
  input  wire logic        i_brake_open_cmd,
  input  wire logic [15:0] i_freq_cmd,
  output logic             o_run_cmd,
  output logic             o_accel,
  output logic      [15:0] o_out_freq,
  output logic             o_brake_open_req,
  output logic      [31:0] o_pos,
  output logic             o_pos_valid
);
  logic [1:0] ph_reg;

  assign o_run_cmd        = i_start;
  assign o_accel          = i_start & i_accel_req;
  assign o_brake_open_req = i_start;

  always_ff @(posedge i_clk) begin
    // Once run is withdrawn the drive follows the manager's stop ramp
    o_out_freq <= i_run_en ? i_target : i_freq_cmd;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ph_reg      <= 2'd0;
      o_pos       <= 32'h0000_0000;
      o_pos_valid <= 1'b0;
    end else begin
      ph_reg      <= ph_reg + 2'd1;
      o_pos_valid <= i_meter_on && ph_reg == 2'd3;
      if (i_meter_on && ph_reg == 2'd3 && i_brake_open_cmd) begin
        o_pos <= o_pos + {16'h0000, i_step};
      end
    end
  end
endmodule

// >>> tb_system_failure_manager.sv
// Self-checking bench for the system failure manager
`timescale 1ns/1ps
module tb_system_failure_manager;
  import sfm_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [9:0]  fsrc = 10'h000;
  logic        start = 1'b0;
  logic        accel_req = 1'b0;
  logic        meter_on = 1'b0;
  logic [15:0] target = 16'h0400;
  logic [15:0] step = 16'h0000;
  logic [31:0] seed = 32'h0000_9DEE;
  logic [31:0] prdata, pos, rd, r;
  logic        pready, pslverr, err, run_cmd, accel, brk_req, pos_valid;
  logic        fo, brk, run_en, creep, sway, adapt;
  logic [15:0] ofreq, fcmd, mon;
  int          fail_count = 0;
  int          checks_done = 0;
  int          filt, prev_pos, d;
  int          shift = 4;

  always #5 clk = ~clk;

  sfm_top sfm_top_i (.i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_fail_src(fsrc), .i_run_cmd(run_cmd),
    .i_accel(accel), .i_out_freq(ofreq), .i_brake_open_req(brk_req), .i_pos(pos),
    .i_pos_valid(pos_valid), .o_failure_output(fo), .o_brake_open_cmd(brk),
    .o_run_en(run_en), .o_freq_cmd(fcmd), .o_creep_en(creep), .o_antisway_en(sway),
    .o_adaptive_en(adapt), .o_monitor(mon));

  sfm_drive_model sfm_drive_model_i (.i_clk(clk), .i_rstn(rstn), .i_start(start),
    .i_accel_req(accel_req), .i_meter_on(meter_on), .i_target(target), .i_step(step),
    .i_run_en(run_en), .i_brake_open_cmd(brk), .o_run_cmd(run_cmd), .o_accel(accel),
    .i_freq_cmd(fcmd),
    .o_out_freq(ofreq), .o_brake_open_req(brk_req), .o_pos(pos), .o_pos_valid(pos_valid));

  // Lag filter on the position difference, kept in plain integers
  always @(posedge clk) begin
    if (!rstn) begin
      filt = 0;
      prev_pos = 0;
    end else if (pos_valid === 1'b1) begin
      d = int'((pos - prev_pos) & 32'h0000_ffff);
      filt = filt + (((d <<< 8) - filt) >>> shift);
      prev_pos = pos;
    end
  end

  function logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int prio(input logic [9:0] s, input logic [15:0] a);
    if (s[7]) return 8;
    if (s[6] && a[6]) return 7;
    if (s[8] && a[8]) return 9;
    for (int i = 0; i < 10; i++) begin
      if (s[i]) return i + 1;
    end
    return 0;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    pen <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rst(input int n);
    start <= 1'b0;
    rstn <= 1'b0;
    fsrc <= 10'h000;
    cyc(n);
    rstn <= 1'b1;
    cyc(2);
  endtask

  task automatic run_fail(input logic [9:0] s1, input logic [9:0] s2, input logic [15:0] m,
                          input logic [15:0] a, input logic pol);
    logic [9:0] e1, e;
    int         c, c1;
    logic       bk;
    rst(3);
    apb(1, OFS_MASK, {16'h0000, m});
    apb(1, OFS_ACTION, {16'h0000, a});
    apb(1, OFS_CTRL, {30'h0, pol, 1'b1});
    apb(1, OFS_DSTEP, 32'h0000_0100);
    apb(1, OFS_MONSEL, {24'h0, MONSEL_CODE});
    start <= 1'b1;
    cyc(4);
    chk(fo, pol);
    fsrc <= s1;
    cyc(3);
    fsrc <= s2;
    cyc(3);
    fsrc <= 10'h000;
    cyc(4);
    e1 = s1 & m[9:0];
    e = e1 | (s2 & m[9:0]);
    c = prio(e, a);
    c1 = (e1 != 0) ? prio(e1, a) : c;
    // A brake stop once begun is never turned back into a deceleration
    bk = (c == 8) || (c > 0 && a[c-1]) || (c1 == 8) || (c1 > 0 && a[c1-1]);
    chk(fo, (e != 0) ^ pol);
    chk(mon[15:8], c);
    chk(mon[7:0], c1);
    chk(run_en, e == 0);
    chk(creep, e == 0);
    chk(brk, !bk);
    if (bk) chk(fcmd, 0);
  endtask

  task automatic decel_case(input logic prof);
    int n;
    accel_req <= !prof;
    rst(3);
    apb(1, OFS_CTRL, {31'h0, prof});
    apb(1, OFS_DSTEP, 32'h0000_0100);
    start <= 1'b1;
    cyc(4);
    fsrc <= 10'h004;
    cyc(3);
    chk(sway, !prof);
    chk(adapt, !prof);
    if (!prof) begin
      cyc(200);
      chk(fcmd, target);
      accel_req <= 1'b0;
    end
    n = 0;
    while (fcmd === target && n < 400) begin
      cyc(1);
      n++;
    end
    chk(fcmd, target - (prof ? 16'h0100 : 16'h0001));
    n = 0;
    while (brk !== 1'b0 && n < 9000) begin
      cyc(1);
      n++;
    end
    if (n == 9000) fail_count++;
    chk(fcmd, 0);
    $display("test decel profile %0d done", prof);
  endtask

  initial begin
    #300_000;
    fail_count++;
    wrap_up();
  end

  initial begin
    logic [7:0]  ra [7] = '{OFS_MASK, OFS_ACTION, OFS_CTRL, OFS_FILTER, OFS_MONSEL,
                            OFS_OSPEED, OFS_DSTEP};
    logic [31:0] rv [7] = '{RST_MASK, RST_ACTION, RST_CTRL, RST_FILTER, RST_MONSEL,
                            RST_OSPEED, RST_DSTEP};
    rst(16);
    for (int i = 0; i < 7; i++) begin
      apb(0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1, 8'h40, 32'h0000_00ff);
    chk(err, 1'b1);
    apb(1, OFS_CODEMON, 32'h0000_ffff);
    apb(0, OFS_CODEMON, 32'h0);
    chk(rd, 0);
    r = nxt();
    apb(1, OFS_MASK, {16'h0000, r[15:0]});
    apb(0, OFS_MASK, 32'h0);
    chk(rd, {16'h0000, r[15:0]});
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      run_fail(10'(1 << i), 10'h000, 16'hffff, 16'h0000, 1'b0);
      run_fail(10'(1 << i), 10'h000, 16'hffff, 16'hffff, 1'b1);
    end
    run_fail(10'h004, 10'h080, 16'hffff, 16'h0000, 1'b0);
    run_fail(10'h010, 10'h000, 16'hffef, 16'h0000, 1'b0);
    run_fail(10'h142, 10'h000, 16'hffff, 16'h0140, 1'b0);
    run_fail(10'h102, 10'h000, 16'hffff, 16'h0000, 1'b0);
    run_fail(10'h100, 10'h001, 16'hffff, 16'h0100, 1'b1);
    for (int i = 0; i < 8; i++) begin
      r = nxt();
      run_fail(r[9:0], r[19:10], {6'h00, r[31:22]}, nxt() & 32'h0000_03ff, r[20]);
    end
    $display("test failure latching done");
    decel_case(1'b1);
    decel_case(1'b0);
    rst(3);
    r = nxt();
    shift = 3;
    apb(1, OFS_FILTER, 32'h0000_0003);
    step <= {8'h00, r[7:0] | 8'h01};
    start <= 1'b1;
    meter_on <= 1'b1;
    cyc(300);
    meter_on <= 1'b0;
    cyc(6);
    apb(0, OFS_SPEED, 32'h0);
    chk(rd, {16'h0000, filt[23:8]});
    apb(1, OFS_MONSEL, {24'h0, MONSEL_SPEED});
    cyc(3);
    chk(mon, filt[23:8]);
    $display("test crane speed done");
    wrap_up();
  end
endmodule
